// File: hdl/usb_error_endpoint_vbus_ctrl.sv
`timescale 1ns/1ps
`include "usb_ctrl_defs.svh"
// What this block does
// RULE_01: error flags set by hardware, cleared by writing one; bits 15-8, 6 zero
// RULE_02: software clears flags with a whole word holding ones where needed
// RULE_03: bit stuffing violation sets error flag bit 7
// RULE_04: bytes beyond descriptor count set bit 5 and are not stored
// RULE_05: turnaround time-out sets error flag bit 4
// RULE_06: data field with partial byte sets error flag bit 3
// RULE_07: failed data CRC16 check sets error flag bit 2
// RULE_08: in device mode, token CRC5 failure sets error flag bit 1
// RULE_09: in host mode, end-of-frame error sets error flag bit 1
// RULE_10: failed packet identifier check sets error flag bit 0
// RULE_11: enable register mirrors flag positions, read/write, resets to zero
// RULE_12: summary error flag follows only enabled error flags, read-only
// RULE_13: sixteen endpoint registers; bits 15-8 and bit 5 read zero
// RULE_14: low-speed and retry-disable bits exist only in endpoint zero, host mode
// RULE_15: endpoint zero bit 7 enables direct low-speed connection
// RULE_16: retry-disable clear means hardware retries NAKed transactions
// RULE_17: with receive and transmit enabled, bit 4 forbids SETUP transfers
// RULE_18: bit 3 enables receive, bit 2 enables transmit, both reset off
// RULE_19: bit 1 reports endpoint stalled
// RULE_20: bit 0 enables handshakes; cleared means none are sent
// RULE_21: vbus generator runs only with bit 15 set, else idles at reset level
// RULE_22: polarity bit 9 one gives active-low, idle high; zero the reverse
// RULE_23: bit 8 runs the counter; bits 14-10 and 7-0 read zero
// RULE_24: flags latch regardless of enables; enables gate only the summary
module usb_error_endpoint_vbus_ctrl
    import usb_ctrl_pkg::*;
#(
    parameter int NUM_EP = 16,      // endpoint registers
    parameter int BC_W   = 10       // descriptor byte count width
) (
    input  wire logic              mclk,           // 200 MHz clock
    input  wire logic              srst,           // sync reset, high
    input  wire logic              hsel,           // slave select
    input  wire logic [31:0]       haddr,          // byte address
    input  wire logic [1:0]        htrans,         // transfer type
    input  wire logic              hwrite,         // write when high
    input  wire logic [2:0]        hsize,          // transfer size
    input  wire logic              hready,         // bus ready
    input  wire logic [31:0]       hwdata,         // write data
    output logic      [31:0]       hrdata,         // read data
    output logic                   hreadyout,      // always ready
    output logic                   hresp,          // always okay
    input  wire logic              host_mode,      // 1 host, 0 device
    input  wire logic              stuff_err_evt,  // stuffing violation
    input  wire logic              turnaround_evt, // turnaround expired
    input  wire logic              data_crc_evt,   // crc16 failed
    input  wire logic              token_crc_evt,  // crc5 failed
    input  wire logic              frame_end_evt,  // end-of-frame error
    input  wire logic              pid_err_evt,    // pid check failed
    input  wire logic              rx_pkt_start,   // new data packet
    input  wire logic              rx_byte_valid,  // received byte
    input  wire logic [BC_W-1:0]   bd_byte_count,  // descriptor limit
    output logic                   rx_byte_store,  // byte may be stored
    input  wire logic              rx_eop,         // end of data field
    input  wire logic [2:0]        rx_bit_residue, // leftover bits
    input  wire logic [NUM_EP-1:0] ep_stall_evt,   // endpoint stalled
    output logic      [NUM_EP-1:0] ep_rx_enable,   // receive allowed
    output logic      [NUM_EP-1:0] ep_tx_enable,   // transmit allowed
    output logic      [NUM_EP-1:0] ep_setup_allow, // SETUP allowed
    output logic      [NUM_EP-1:0] ep_handshake_en, // send handshakes
    output logic      [NUM_EP-1:0] ep_stalled,     // stall status
    output logic                   low_speed_direct, // ep0 low speed
    output logic                   nak_retry_en,   // hw NAK retry on
    input  wire logic              pwm_raw,        // raw active level
    output logic                   vbus_pwm_out,   // vbus drive pin
    output logic                   vbus_counter_run, // counter runs
    output logic                   summary_error_irq_flag // enabled error
);

    initial begin
        if (NUM_EP < 1 || NUM_EP > 16 || BC_W < 1 || BC_W > 16) begin
            $error("unsupported parameter values");
        end
    end

    // endpoint register hit for a given byte offset
    // upper offsets must not alias back onto endpoint zero
    function automatic logic ep_hit(input logic [7:0] a);
        ep_hit = (a[7:6] == 2'h1) && (a[1:0] == 2'h0)
              && ({4'h0, a[5:2]} < 8'(NUM_EP));
    endfunction

    logic [7:0]        addr_q;
    logic              wr_q;
    logic              rd_q;
    flag8_type         flags_q;
    flag8_type         en_q;
    flag8_type         ep_q [NUM_EP];
    logic [2:0]        pwm_q;
    logic [BC_W:0]     cnt_q;
    logic [BC_W:0]     cnt_base;
    flag8_type         err_set;
    logic              word_wr;
    logic              overrun;
    logic              partial;
    flag8_type         ep0_mask;

    // address phase capture; only whole-word writes are acted on
    always_ff @(posedge mclk) begin
        if (srst) begin
            addr_q <= 8'h00;
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
        end else if (hready) begin
            addr_q <= haddr[7:0];
            wr_q   <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
            rd_q   <= hsel && htrans[1] && !hwrite;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign word_wr   = wr_q && hready;

    // descriptor byte limit; start of packet restarts the count
    assign cnt_base      = rx_pkt_start ? '0 : cnt_q;
    assign rx_byte_store = rx_byte_valid
                        && (cnt_base < {1'b0, bd_byte_count}); // RULE_04
    assign overrun       = rx_byte_valid && !rx_byte_store;    // RULE_04
    assign partial       = rx_eop && (rx_bit_residue != 3'h0); // RULE_06

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (rx_pkt_start || rx_byte_store) begin
            cnt_q <= cnt_base + (BC_W+1)'(rx_byte_store);
        end
    end

    // hardware set vector; bit 1 meaning depends on role
    always_comb begin
        err_set = 8'h00;
        err_set[`UEV_STUFF_BIT]   = stuff_err_evt;                // RULE_03
        err_set[`UEV_OVERRUN_BIT] = overrun;                      // RULE_04
        err_set[`UEV_TURN_BIT]    = turnaround_evt;               // RULE_05
        err_set[`UEV_PARTIAL_BIT] = partial;                      // RULE_06
        err_set[`UEV_DCRC_BIT]    = data_crc_evt;                 // RULE_07
        err_set[`UEV_TOKFRM_BIT]  = host_mode ? frame_end_evt     // RULE_09
                                              : token_crc_evt;    // RULE_08
        err_set[`UEV_PID_BIT]     = pid_err_evt;                  // RULE_10
    end

    // sticky flags: set beats a same-cycle clear, enables play no part
    always_ff @(posedge mclk) begin
        if (srst) begin
            flags_q <= `UEV_ERR_RST;
        end else begin
            flags_q <= (err_set | (flags_q & ~((word_wr
                && addr_q == `UEV_ERR_FLAGS_OFS) ? hwdata[7:0] : 8'h00)))
                & `UEV_ERR_MASK; // RULE_01 RULE_24
        end
    end

    // error enables
    always_ff @(posedge mclk) begin
        if (srst) begin
            en_q <= `UEV_EN_RST;
        end else if (word_wr && addr_q == `UEV_ERR_EN_OFS) begin
            en_q <= hwdata[7:0] & `UEV_ERR_MASK; // RULE_11
        end
    end

    assign summary_error_irq_flag = |(flags_q & en_q); // RULE_12

    // low-speed and retry bits are stored but only seen in host mode
    assign ep0_mask = host_mode ? `UEV_EP0_HOST_MASK : `UEV_EP_MASK; // RULE_14

    // endpoint control registers, stall status set by hardware wins
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            localparam logic [7:0] OFS = `UEV_EP_BASE_OFS + 8'(4 * g);
            localparam flag8_type  MSK = (g == 0) ? `UEV_EP0_HOST_MASK
                                                  : `UEV_EP_MASK;
            logic sel;
            flag8_type vis;
            assign sel = word_wr && ep_hit(addr_q) && (addr_q == OFS);
            always_ff @(posedge mclk) begin
                if (srst) begin
                    ep_q[g] <= `UEV_EP_RST; // RULE_18
                end else begin
                    ep_q[g] <= (sel ? (hwdata[7:0] & MSK) : ep_q[g])
                             | {6'h00, ep_stall_evt[g], 1'b0}; // RULE_19
                end
            end
            assign vis = (g == 0) ? (ep_q[g] & ep0_mask) : ep_q[g];
            assign ep_rx_enable[g]    = vis[`UEV_EP_RX_BIT];   // RULE_18
            assign ep_tx_enable[g]    = vis[`UEV_EP_TX_BIT];   // RULE_18
            assign ep_setup_allow[g]  = vis[`UEV_EP_RX_BIT]
                                     && vis[`UEV_EP_TX_BIT]
                                     && !vis[`UEV_EP_SETUP_BIT]; // RULE_17
            assign ep_stalled[g]      = vis[`UEV_EP_STALL_BIT]; // RULE_19
            assign ep_handshake_en[g] = vis[`UEV_EP_HSHK_BIT];  // RULE_20
        end
    endgenerate

    assign low_speed_direct = host_mode && ep_q[0][`UEV_EP_LS_BIT]; // RULE_15
    assign nak_retry_en     = host_mode && !ep_q[0][`UEV_EP_RETRY_BIT]; // RULE_16

    // vbus generator control: {enable, polarity, counter}
    always_ff @(posedge mclk) begin
        if (srst) begin
            pwm_q <= `UEV_PWM_RST;
        end else if (word_wr && addr_q == `UEV_PWM_CTRL_OFS) begin
            pwm_q <= {hwdata[`UEV_PWM_EN_BIT], hwdata[`UEV_PWM_POL_BIT],
                      hwdata[`UEV_PWM_CNT_BIT]};
        end
    end

    assign vbus_counter_run = pwm_q[0]; // RULE_23

    // registered pin; polarity inverts the raw level, idle at reset level
    always_ff @(posedge mclk) begin
        if (srst) begin
            vbus_pwm_out <= 1'b0;
        end else begin
            vbus_pwm_out <= pwm_q[2] ? (pwm_raw ^ pwm_q[1]) // RULE_21 RULE_22
                                     : pwm_q[1];
        end
    end

    // read mux over flops; unmapped offsets read zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_q) begin
            if (addr_q == `UEV_ERR_FLAGS_OFS) begin
                hrdata[7:0] = flags_q; // RULE_01
            end else if (addr_q == `UEV_ERR_EN_OFS) begin
                hrdata[7:0] = en_q;
            end else if (addr_q == `UEV_PWM_CTRL_OFS) begin
                hrdata[`UEV_PWM_EN_BIT]  = pwm_q[2];
                hrdata[`UEV_PWM_POL_BIT] = pwm_q[1];
                hrdata[`UEV_PWM_CNT_BIT] = pwm_q[0]; // RULE_23
            end else if (ep_hit(addr_q)) begin
                hrdata[7:0] = (addr_q[5:2] == 4'h0) ? (ep_q[0] & ep0_mask)
                            : ep_q[addr_q[5:2]]; // RULE_13 RULE_14
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_set_beats_clear: assert property (stuff_err_evt && word_wr  // RULE_01
        && addr_q == `UEV_ERR_FLAGS_OFS |=> flags_q[`UEV_STUFF_BIT])
        else $error("flag lost on clear collision");
    a_flag_w1c: assert property (word_wr && addr_q == `UEV_ERR_FLAGS_OFS // RULE_01
        && hwdata[`UEV_PID_BIT] && !pid_err_evt |=> !flags_q[`UEV_PID_BIT])
        else $error("write one did not clear");
    a_flag_sticky: assert property (flags_q[`UEV_DCRC_BIT] && !word_wr // RULE_24
        |=> flags_q[`UEV_DCRC_BIT])
        else $error("flag dropped without clear");
    a_reserved_zero: assert property (flags_q[6] == 1'b0 && en_q[6] == 1'b0) // RULE_01
        else $error("reserved flag bit set");
    a_overrun_trunc: assert property (overrun |-> !rx_byte_store // RULE_04
        ##1 flags_q[`UEV_OVERRUN_BIT])
        else $error("overrun not flagged or stored");
    a_bit1_role: assert property (host_mode && token_crc_evt && !frame_end_evt // RULE_08
        && !flags_q[1] && !word_wr |=> !flags_q[1])
        else $error("crc5 flagged in host mode");
    a_partial_byte: assert property (rx_eop && rx_bit_residue != 3'h0 // RULE_06
        |=> flags_q[`UEV_PARTIAL_BIT])
        else $error("partial byte not flagged");
    a_summary_gate: assert property ($rose(summary_error_irq_flag) // RULE_12
        |-> |(flags_q & en_q & $past(en_q)) || $changed(en_q))
        else $error("summary set without enabled flag");
    a_ep0_device: assert property (!host_mode |-> !low_speed_direct // RULE_14
        && !nak_retry_en)
        else $error("ep0 host bits visible in device mode");
    // pin is registered, so it shows last cycle's polarity
    a_pwm_idle: assert property (!pwm_q[2] // RULE_21
        |=> vbus_pwm_out == $past(pwm_q[1]))
        else $error("vbus pin not at reset level");
    a_pwm_follow: assert property (pwm_q[2] // RULE_22
        |=> vbus_pwm_out == ($past(pwm_raw) ^ $past(pwm_q[1])))
        else $error("vbus pin not following raw level");
    a_stuff_set: assert property (stuff_err_evt |=> flags_q[`UEV_STUFF_BIT]) // RULE_03
        else $error("stuffing error not flagged");
    a_eof_host: assert property (host_mode && frame_end_evt // RULE_09
        |=> flags_q[`UEV_TOKFRM_BIT])
        else $error("end-of-frame error not flagged");
    a_summary_mask: assert property (en_q == 8'h00 // RULE_12
        |-> !summary_error_irq_flag)
        else $error("summary set with all enables off");
    a_store_valid: assert property (rx_byte_store |-> rx_byte_valid) // RULE_04
        else $error("byte stored without strobe");
    a_stall_set: assert property (ep_stall_evt[0] |=> ep_stalled[0]) // RULE_19
        else $error("stall event not reported");
    a_setup_ignored: assert property (!(ep_rx_enable[0] && ep_tx_enable[0]) // RULE_17
        |-> !ep_setup_allow[0])
        else $error("setup allowed without both directions");

    c_overrun: cover property (rx_byte_valid ##1 overrun);
    c_collide: cover property (stuff_err_evt && word_wr);
    c_summary: cover property ($rose(summary_error_irq_flag));
    c_pwm_run: cover property (pwm_q[2] && pwm_q[1] && pwm_raw);
    c_ep_stall: cover property (ep_stall_evt[0] ##1 ep_stalled[0]);

endmodule

// File: include/usb_ctrl_defs.svh
`ifndef USB_CTRL_DEFS_SVH
`define USB_CTRL_DEFS_SVH
// register byte offsets
`define UEV_ERR_FLAGS_OFS 8'h00
`define UEV_ERR_EN_OFS    8'h04
`define UEV_PWM_CTRL_OFS  8'h08
`define UEV_EP_BASE_OFS   8'h40
// error flag and enable bit positions
`define UEV_STUFF_BIT     7
`define UEV_OVERRUN_BIT   5
`define UEV_TURN_BIT      4
`define UEV_PARTIAL_BIT   3
`define UEV_DCRC_BIT      2
`define UEV_TOKFRM_BIT    1
`define UEV_PID_BIT       0
`define UEV_ERR_MASK      8'hBF
// endpoint control bit positions
`define UEV_EP_LS_BIT     7
`define UEV_EP_RETRY_BIT  6
`define UEV_EP_SETUP_BIT  4
`define UEV_EP_RX_BIT     3
`define UEV_EP_TX_BIT     2
`define UEV_EP_STALL_BIT  1
`define UEV_EP_HSHK_BIT   0
`define UEV_EP_MASK       8'h1F
`define UEV_EP0_HOST_MASK 8'hDF
// vbus generator control bit positions
`define UEV_PWM_EN_BIT    15
`define UEV_PWM_POL_BIT   9
`define UEV_PWM_CNT_BIT   8
// reset values
`define UEV_ERR_RST       8'h00
`define UEV_EN_RST        8'h00
`define UEV_EP_RST        8'h00
`define UEV_PWM_RST       3'h0
`endif

// File: include/usb_ctrl_pkg.sv
package usb_ctrl_pkg;
    typedef logic [7:0]  flag8_type;
    typedef logic [31:0] word_type;
endpackage

// File: dv/usb_far_side_model.sv
`timescale 1ns/1ps
module usb_far_side_model (
    input  wire logic        mclk,           // bench clock
    input  wire logic        rx_byte_store,  // device keeps this byte
    output logic      [5:0]  err_evt,        // error event pulses
    output logic             rx_pkt_start,   // packet begins
    output logic             rx_byte_valid,  // byte strobe
    output logic             rx_eop,         // end of data field
    output logic      [2:0]  rx_bit_residue, // leftover bits at eop
    output logic      [15:0] ep_stall_evt,   // stall pulses
    output int               stored          // bytes kept this packet
);
    // quiet line levels at time zero
    initial begin
        err_evt = '0;
        rx_pkt_start = 1'b0;
        rx_byte_valid = 1'b0;
        rx_eop = 1'b0;
        rx_bit_residue = 3'h5;
        ep_stall_evt = '0;
        stored = 0;
    end
    // count bytes the device accepted; a start byte is the first of its packet
    always @(posedge mclk) begin
        if (rx_pkt_start)
            stored <= int'(rx_byte_store);
        else
            stored <= stored + int'(rx_byte_store);
    end
    task automatic pulse_err(input int k);
        @(posedge mclk);
        err_evt[k] <= 1'b1;
        @(posedge mclk);
        err_evt[k] <= 1'b0;
    endtask
    task automatic stall(input int e);
        @(posedge mclk);
        ep_stall_evt[e] <= 1'b1;
        @(posedge mclk);
        ep_stall_evt[e] <= 1'b0;
    endtask
    task automatic send_pkt(input int n, input logic [2:0] res);
        @(posedge mclk);
        rx_pkt_start <= 1'b1;
        for (int i = 0; i < n; i++) begin
            rx_byte_valid <= 1'b1;
            @(posedge mclk);
            rx_pkt_start <= 1'b0;
        end
        rx_byte_valid <= 1'b0;
        rx_eop <= 1'b1;
        rx_bit_residue <= res;
        @(posedge mclk);
        rx_eop <= 1'b0;
        rx_bit_residue <= ~res; // released, so never the last value
    endtask
endmodule

// File: dv/test_usb_error_endpoint_vbus_ctrl.sv
`timescale 1ns/1ps
`include "usb_ctrl_defs.svh"
module test_usb_error_endpoint_vbus_ctrl;
    import usb_ctrl_pkg::*;
    logic        mclk, srst, hsel, hwrite, host_mode, pwm_raw, hresp, hreadyout;
    logic        rx_pkt_start, rx_byte_valid, rx_eop, rx_byte_store, vbus_pwm_out;
    logic        low_speed_direct, nak_retry_en, vbus_counter_run, summary_error_irq_flag;
    logic [1:0]  htrans;
    logic [2:0]  hsize, rx_bit_residue;
    logic [5:0]  err_evt;
    logic [9:0]  bd_byte_count;
    logic [15:0] ep_stall_evt, ep_rx, ep_tx, ep_setup, ep_hshk, ep_stl;
    word_type    haddr, hwdata, hrdata;
    int          stored, error_cnt, checks_done;
    usb_error_endpoint_vbus_ctrl i_usb_error_endpoint_vbus_ctrl (.mclk(mclk), .srst(srst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .host_mode(host_mode), .stuff_err_evt(err_evt[5]),
        .turnaround_evt(err_evt[4]), .data_crc_evt(err_evt[2]), .token_crc_evt(err_evt[1]),
        .frame_end_evt(err_evt[3]), .pid_err_evt(err_evt[0]), .rx_pkt_start(rx_pkt_start),
        .rx_byte_valid(rx_byte_valid), .bd_byte_count(bd_byte_count),
        .rx_byte_store(rx_byte_store), .rx_eop(rx_eop), .rx_bit_residue(rx_bit_residue),
        .ep_stall_evt(ep_stall_evt), .ep_rx_enable(ep_rx), .ep_tx_enable(ep_tx),
        .ep_setup_allow(ep_setup), .ep_handshake_en(ep_hshk), .ep_stalled(ep_stl),
        .low_speed_direct(low_speed_direct), .nak_retry_en(nak_retry_en), .pwm_raw(pwm_raw),
        .vbus_pwm_out(vbus_pwm_out), .vbus_counter_run(vbus_counter_run),
        .summary_error_irq_flag(summary_error_irq_flag));
    usb_far_side_model i_usb_far_side_model (.mclk(mclk), .rx_byte_store(rx_byte_store),
        .err_evt(err_evt), .rx_pkt_start(rx_pkt_start), .rx_byte_valid(rx_byte_valid),
        .rx_eop(rx_eop), .rx_bit_residue(rx_bit_residue), .ep_stall_evt(ep_stall_evt),
        .stored(stored));
    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic end_sim();
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // a hang stops the run at 20000 cycles, far above the whole run's few hundred cycles
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
    task automatic chk(input string what, input word_type exp, input word_type got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // the slave may stretch; wait for hready but never forever
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) chk1("hready", 1'b1, 1'b0);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input word_type wd,
                       output word_type rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk1("hresp", 1'b0, hresp);
    endtask
    task automatic wr(input logic [7:0] a, input word_type d);
        word_type t;
        bus(1'b1, a, d, t);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input word_type exp);
        word_type t;
        bus(1'b0, a, 32'h0, t);
        chk(what, exp, t);
    endtask
    // which flag a far-side event should raise in a given mode
    function automatic flag8_type err_mask(input int k, input logic h);
        case (k)
            0: return 8'h01;
            1: return h ? 8'h00 : 8'h02;
            2: return 8'h04;
            3: return h ? 8'h02 : 8'h00;
            4: return 8'h10;
            default: return 8'h80;
        endcase
    endfunction
    // main sequence
    initial begin
        word_type  d, m;
        flag8_type f;
        int        n;
        srst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = '0;
        hsize = 3'h2;
        hwdata = '0;
        host_mode = 1'b0;
        pwm_raw = 1'b0;
        bd_byte_count = 10'h4;
        error_cnt = 0;
        checks_done = 0;
        void'($urandom(83));
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        wr(8'h20, 32'hFFFF_FFFF);
        rdc("unmapped", 8'h20, 32'h0);
        for (int i = 0; i < 3; i++) rdc("reset reg", 8'(4 * i), 32'h0);
        for (int e = 0; e < 16; e++) rdc("reset ep", 8'h40 + 8'(4 * e), 32'h0);
        wr(`UEV_ERR_EN_OFS, 32'hFFFF_FFFF);
        rdc("enable bits", `UEV_ERR_EN_OFS, 32'hBF);
        wr(`UEV_ERR_EN_OFS, 32'h0);
        // every event in both modes: latch, mask, partial clear, full clear
        for (int h = 0; h < 2; h++) begin
            host_mode <= h[0];
            for (int k = 0; k < 6; k++) begin
                f = err_mask(k, h[0]);
                i_usb_far_side_model.pulse_err(k);
                rdc("err flags", `UEV_ERR_FLAGS_OFS, {24'h0, f});
                chk1("summary off", 1'b0, summary_error_irq_flag);
                wr(`UEV_ERR_EN_OFS, {24'h0, f});
                @(posedge mclk);
                chk1("summary on", f != 8'h0, summary_error_irq_flag);
                wr(`UEV_ERR_FLAGS_OFS, {24'h0, ~f});
                rdc("flag kept", `UEV_ERR_FLAGS_OFS, {24'h0, f});
                wr(`UEV_ERR_FLAGS_OFS, 32'hFFFF_FFFF);
                rdc("flag cleared", `UEV_ERR_FLAGS_OFS, 32'h0);
                wr(`UEV_ERR_EN_OFS, 32'h0);
            end
        end
        // several flags at once, random clear mask in device mode
        host_mode <= 1'b0;
        for (int k = 0; k < 6; k++) i_usb_far_side_model.pulse_err(k);
        m = $urandom;
        wr(`UEV_ERR_FLAGS_OFS, m);
        rdc("w1c mix", `UEV_ERR_FLAGS_OFS, {24'h0, 8'h97 & ~m[7:0]});
        wr(`UEV_ERR_FLAGS_OFS, 32'hFF);
        // exact fit first, then overruns with a partial last byte
        for (int t = 0; t < 4; t++) begin
            n = 1 + $urandom_range(6);
            bd_byte_count <= 10'(n);
            i_usb_far_side_model.send_pkt((t == 0) ? n : n + 1 + t, 3'(t));
            chk("bytes kept", n, stored);
            rdc("rx flags", `UEV_ERR_FLAGS_OFS, (t == 0) ? 32'h0 : 32'h28);
            wr(`UEV_ERR_FLAGS_OFS, 32'hFF);
        end
        // endpoints in host mode, with setup allowed and forbidden corners
        host_mode <= 1'b1;
        for (int e = 0; e < 16; e++) begin
            d = (e == 1) ? 32'h1C : (e == 2) ? 32'h0C : $urandom;
            m = (e == 0) ? 32'hDF : 32'h1F;
            wr(8'h40 + 8'(4 * e), d);
            rdc("ep reg", 8'h40 + 8'(4 * e), d & m);
            chk1("ep rx", d[3], ep_rx[e]);
            chk1("ep tx", d[2], ep_tx[e]);
            chk1("ep setup", d[3] & d[2] & ~d[4], ep_setup[e]);
            chk1("ep hshk", d[0], ep_hshk[e]);
            chk1("ep stall", d[1], ep_stl[e]);
            if (e == 0) chk1("low speed", d[7], low_speed_direct);
            if (e == 0) chk1("nak retry", ~d[6], nak_retry_en);
            i_usb_far_side_model.stall(e);
            rdc("ep stall set", 8'h40 + 8'(4 * e), (d & m) | 32'h2);
        end
        // endpoint zero host bits vanish in device mode but are kept
        host_mode <= 1'b0;
        wr(`UEV_EP_BASE_OFS, 32'hC0);
        rdc("ep0 device", `UEV_EP_BASE_OFS, 32'h0);
        chk1("ls device", 1'b0, low_speed_direct);
        chk1("retry device", 1'b0, nak_retry_en);
        host_mode <= 1'b1;
        rdc("ep0 host", `UEV_EP_BASE_OFS, 32'hC0);
        chk1("ls host", 1'b1, low_speed_direct);
        chk1("retry off", 1'b0, nak_retry_en);
        // every enable, polarity and counter combination, then random words
        for (int t = 0; t < 12; t++) begin
            d = (t < 8) ? {16'h0, t[2], 5'h1F, t[1], t[0], 8'hFF} : $urandom;
            pwm_raw <= 1'($urandom);
            wr(`UEV_PWM_CTRL_OFS, d);
            rdc("pwm ctrl", `UEV_PWM_CTRL_OFS, d & 32'h8300);
            chk1("pwm out", d[15] ? pwm_raw ^ d[9] : d[9], vbus_pwm_out);
            chk1("pwm count", d[8], vbus_counter_run);
            pwm_raw <= ~pwm_raw;
            repeat (2) @(posedge mclk);
            chk1("pwm follow", d[15] ? pwm_raw ^ d[9] : d[9], vbus_pwm_out);
        end
        // second reset in mid-run clears everything, a live flag too
        wr(`UEV_ERR_EN_OFS, 32'hFF);
        i_usb_far_side_model.pulse_err(0);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        chk1("pwm reset", 1'b0, vbus_pwm_out);
        rdc("pwm after", `UEV_PWM_CTRL_OFS, 32'h0);
        rdc("ep0 after", `UEV_EP_BASE_OFS, 32'h0);
        rdc("flags after", `UEV_ERR_FLAGS_OFS, 32'h0);
        rdc("enables after", `UEV_ERR_EN_OFS, 32'h0);
        chk1("summary after", 1'b0, summary_error_irq_flag);
        end_sim();
    end
endmodule
